//--- cvw_half_timer.sv
`timescale 1ns/1ns
// ----------------------------------------
// half-second phase timer
// ----------------------------------------
module cvw_half_timer import cvw_pkg::*; #(
  parameter int HALF_CYCLES = CVW_HALF_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  output logic o_second_half,
  output logic o_second_tick,
  output logic o_near_tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  cvw_half_t state_reg;
  cvw_half_t state_next;
  logic last;
  assign last = (cnt_reg == 32'(HALF_CYCLES - 1));
  // next count and phase
  always_comb begin
    cnt_next = last ? 32'h0 : cnt_reg + 32'h1;
    state_next = state_reg;
    if (last) begin
      unique case (state_reg)
        CVW_FIRST_HALF: state_next = CVW_SECOND_HALF;
        CVW_SECOND_HALF: state_next = CVW_FIRST_HALF;
        default: state_next = CVW_FIRST_HALF;
      endcase
    end
  end
  // registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cnt_reg <= 32'h0;
      state_reg <= CVW_FIRST_HALF;
    end else begin
      cnt_reg <= cnt_next;
      state_reg <= state_next;
    end
  end
  assign o_second_half = (state_reg == CVW_SECOND_HALF);
  assign o_second_tick = last && (state_reg == CVW_SECOND_HALF);
  assign o_near_tick = (state_reg == CVW_SECOND_HALF) &&
                       (cnt_reg >= 32'(HALF_CYCLES - CVW_RIPPLE_CYCLES));
endmodule

//--- cvw_pkg.sv
package cvw_pkg;
  // ----------------------------------------
  // register map (word index = byte offset)
  // ----------------------------------------
  localparam logic [3:0] CVW_ADDR_CONFIG = 4'h0; // clock_config_calibration
  localparam logic [3:0] CVW_ADDR_VALUE_HIGH = 4'h1; // value_window_high
  localparam logic [3:0] CVW_ADDR_VALUE_LOW = 4'h2; // value_window_low
  localparam logic [3:0] CVW_ADDR_STATUS = 4'h3; // ripple status
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CVW_BIT_HALF_SECOND = 11;
  localparam int CVW_BIT_OUTPUT_ENABLE = 10;
  localparam int CVW_BIT_POINTER_HI = 9;
  localparam int CVW_BIT_POINTER_LO = 8;
  localparam logic [15:0] CVW_CONFIG_RESET = 16'h0000;
  localparam logic [7:0] CVW_CAL_RESET = 8'h00;
  // ----------------------------------------
  // pointer codes
  // ----------------------------------------
  localparam logic [1:0] CVW_PTR_ZERO = 2'h0;
  localparam logic [1:0] CVW_PTR_ONE = 2'h1;
  localparam logic [1:0] CVW_PTR_TWO = 2'h2;
  localparam logic [1:0] CVW_PTR_THREE = 2'h3;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CVW_CLK_HZ = 50000000;
  localparam int CVW_SECOND_MS = 1000;
  localparam int CVW_HALF_CYCLES = (CVW_CLK_HZ / 1000) * CVW_SECOND_MS / 2;
  localparam int CVW_RIPPLE_CYCLES = 32; // window before second edge flagged as ripple
  typedef enum logic [1:0] {
    CVW_FIRST_HALF = 2'b01,
    CVW_SECOND_HALF = 2'b10
  } cvw_half_t;
endpackage

//--- cvw_value_window.sv
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns
// Function
// - half-second flag reads 1 in second half of each second, else 0
// - clock output pin driven only while output enable bit is 1
// - two-bit pointer selects which field pair the value windows show
// - each high window read or write decrements pointer, stopping at 00
// - high byte shows minutes, weekday, month; pointer 11 reserved
// - low byte shows seconds, hours, day, year for pointer 00 to 11
// - config register cleared only by power-on reset, not other resets
// - ripple flag is 1 while window values may change during a read
module cvw_value_window import cvw_pkg::*; #(
  parameter int HALF_CYCLES = CVW_HALF_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_por_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_seconds,
  input wire logic [7:0] i_minutes,
  input wire logic [7:0] i_hours,
  input wire logic [7:0] i_weekday,
  input wire logic [7:0] i_day,
  input wire logic [7:0] i_month,
  input wire logic [7:0] i_year,
  input wire logic i_clock_out,
  output logic [15:0] o_rdata,
  output logic o_clock_pin,
  output logic o_clock_pin_oe,
  output logic o_second_tick
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [1:0] ptr_reg;
  logic [1:0] ptr_next;
  logic oe_reg;
  logic oe_next;
  logic [7:0] cal_reg;
  logic [7:0] cal_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic second_half;
  logic near_tick;
  logic hi_access;

  // field pair lookup for the high byte
  function automatic logic [7:0] high_field(input logic [1:0] p, input logic [7:0] mi,
                                            input logic [7:0] wd, input logic [7:0] mo);
    unique case (p)
      CVW_PTR_ZERO: high_field = mi;
      CVW_PTR_ONE: high_field = wd;
      CVW_PTR_TWO: high_field = mo;
      default: high_field = 8'h00; // reserved code
    endcase
  endfunction

  // field lookup for the low byte
  function automatic logic [7:0] low_field(input logic [1:0] p, input logic [7:0] se,
                                           input logic [7:0] ho, input logic [7:0] dy,
                                           input logic [7:0] yr);
    unique case (p)
      CVW_PTR_ZERO: low_field = se;
      CVW_PTR_ONE: low_field = ho;
      CVW_PTR_TWO: low_field = dy;
      default: low_field = yr;
    endcase
  endfunction

  // ----------------------------------------
  // half-second timer
  // ----------------------------------------
  cvw_half_timer #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .o_second_half(second_half),
    .o_second_tick(o_second_tick),
    .o_near_tick(near_tick)
  );

  assign hi_access = (i_rd || i_wr) && (i_addr == CVW_ADDR_VALUE_HIGH);

  // ----------------------------------------
  // config register next values
  // ----------------------------------------
  always_comb begin
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    cal_next = cal_reg;
    if (i_wr && i_addr == CVW_ADDR_CONFIG) begin
      oe_next = i_wdata[CVW_BIT_OUTPUT_ENABLE];
      ptr_next = i_wdata[CVW_BIT_POINTER_HI:CVW_BIT_POINTER_LO];
      cal_next = i_wdata[7:0];
    end else if (hi_access) begin
      if (ptr_reg != CVW_PTR_ZERO) begin
        ptr_next = ptr_reg - 2'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_por_nrst) begin
      ptr_reg <= CVW_CONFIG_RESET[CVW_BIT_POINTER_HI:CVW_BIT_POINTER_LO];
      oe_reg <= CVW_CONFIG_RESET[CVW_BIT_OUTPUT_ENABLE];
      cal_reg <= CVW_CAL_RESET;
    end else begin
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      cal_reg <= cal_next;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rdata_next = 16'h0000;
    if (i_rd) begin
      unique case (i_addr)
        CVW_ADDR_CONFIG: begin
          rdata_next[CVW_BIT_HALF_SECOND] = second_half;
          rdata_next[CVW_BIT_OUTPUT_ENABLE] = oe_reg;
          rdata_next[CVW_BIT_POINTER_HI:CVW_BIT_POINTER_LO] = ptr_reg;
          rdata_next[7:0] = cal_reg;
        end
        CVW_ADDR_VALUE_HIGH, CVW_ADDR_VALUE_LOW: begin
          rdata_next[15:8] = high_field(ptr_reg, i_minutes, i_weekday, i_month);
          rdata_next[7:0] = low_field(ptr_reg, i_seconds, i_hours, i_day, i_year);
        end
        CVW_ADDR_STATUS: begin
          rdata_next[0] = near_tick;
        end
        default: rdata_next = 16'h0000; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_clock_pin_oe = oe_reg;
  assign o_clock_pin = oe_reg & i_clock_out;
endmodule

//--- cvw_value_window_bench.sv
`timescale 1ns/1ns
// ----------------------------------------
// value window bench
// ----------------------------------------
module cvw_value_window_bench import cvw_pkg::*;;
  logic i_ref_clk = 0, i_nrst = 0, i_por_nrst = 0, i_wr = 0, i_rd = 0, i_clock_out = 0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000, o_rdata, d;
  logic o_clock_pin, o_clock_pin_oe, o_second_tick;
  // counter fields from the clock unit: seconds, minutes, hours, weekday, day, month, year
  logic [7:0] f [7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77};
  int errors = 0, n_tests = 0, k;
  logic [15:0] walk [5] = '{16'h0077, 16'h6655, 16'h4433, 16'h2211, 16'h2211};
  cvw_value_window #(.HALF_CYCLES(40)) i_cvw_value_window (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_por_nrst(i_por_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_seconds(f[0]), .i_minutes(f[1]), .i_hours(f[2]), .i_weekday(f[3]), .i_day(f[4]),
    .i_month(f[5]), .i_year(f[6]), .i_clock_out(i_clock_out), .o_rdata(o_rdata),
    .o_clock_pin(o_clock_pin), .o_clock_pin_oe(o_clock_pin_oe), .o_second_tick(o_second_tick));
  // clock generator
  initial begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_ref_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_ref_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // counts set samples of one bit over one full second
  task automatic scan(input logic [3:0] a, input int b, input int exp);
    int ones;
    ones = 0;
    for (int i = 0; i < 40; i++) begin
      rd(a, d);
      ones += d[b];
    end
    chk(16'(ones), 16'(exp));
  endtask
  task automatic stop_test;
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (3000) @(posedge i_ref_clk);
    errors++;
    stop_test;
  end
  // test sequence
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_nrst <= 1'b1; i_por_nrst <= 1'b1; i_clock_out <= 1'b1;
    rd(CVW_ADDR_CONFIG, d); chk(d & 16'h0f00, 16'h0000);
    wr(CVW_ADDR_CONFIG, 16'h0f00); rd(CVW_ADDR_CONFIG, d); chk(d & 16'h0f00, 16'h0700);
    chk({15'h0, o_clock_pin}, 16'h0001);
    // system reset only, launched on a rising edge
    @(posedge i_ref_clk);
    i_nrst <= 1'b0; repeat (2) @(posedge i_ref_clk); i_nrst <= 1'b1;
    rd(CVW_ADDR_CONFIG, d); chk(d & 16'h0700, 16'h0700);
    for (k = 0; k < 5; k++) begin
      rd(CVW_ADDR_VALUE_HIGH, d); chk(d, walk[k]);
    end
    rd(CVW_ADDR_VALUE_LOW, d); rd(CVW_ADDR_VALUE_LOW, d); chk(d, 16'h2211);
    wr(CVW_ADDR_CONFIG, 16'h0600); wr(CVW_ADDR_VALUE_HIGH, 16'h0000);
    rd(CVW_ADDR_VALUE_LOW, d); chk(d, 16'h4433);
    scan(CVW_ADDR_CONFIG, CVW_BIT_HALF_SECOND, 20);
    scan(CVW_ADDR_STATUS, 0, 16);
    // two second ticks in any two full seconds
    k = 0;
    repeat (160) begin
      @(posedge i_ref_clk);
      #1 if (o_second_tick === 1'b1) k++;
    end
    chk(16'(k), 16'h0002);
    // enable was set, clearing it must drop the pin
    chk({15'h0, o_clock_pin}, 16'h0001);
    wr(CVW_ADDR_CONFIG, 16'h0000);
    @(negedge i_ref_clk);
    chk({15'h0, o_clock_pin}, 16'h0000);
    // live seconds field through the low byte at pointer 00
    @(posedge i_ref_clk);
    f[0] <= 8'h5a;
    rd(CVW_ADDR_VALUE_LOW, d);
    chk(d, 16'h225a);
    wr(CVW_ADDR_CONFIG, 16'h0700);
    i_por_nrst <= 1'b0; @(posedge i_ref_clk); i_por_nrst <= 1'b1;
    rd(CVW_ADDR_CONFIG, d); chk(d & 16'h0700, 16'h0000);
    stop_test;
  end
endmodule

//--- cvw_value_window_monitor.sv
`timescale 1ns/1ns
// ----------------------------------------
// value window checker
// ----------------------------------------
module cvw_value_window_monitor import cvw_pkg::*; #(
  parameter int HALF_CYCLES = 40
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_por_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_clock_out,
  input wire logic [15:0] o_rdata,
  input wire logic o_clock_pin,
  input wire logic o_clock_pin_oe,
  input wire logic o_second_tick
);
  int cnt;
  logic seen;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // cycles since the last second tick
  always_ff @(posedge i_ref_clk) begin
    cnt <= (!i_nrst || o_second_tick) ? 0 : cnt + 1;
    seen <= i_nrst && (seen || o_second_tick);
  end
  sequence s_low_rd;
    i_rd && i_addr == CVW_ADDR_VALUE_LOW;
  endsequence
  sequence s_low_twice;
    s_low_rd ##2 s_low_rd;
  endsequence
  a_second_period: assert property (seen |-> (o_second_tick ? cnt == 2*HALF_CYCLES-1 : cnt < 2*HALF_CYCLES-1))
    else $error("second tick spacing wrong");
  a_pin_follows_oe: assert property (o_clock_pin == (o_clock_pin_oe & i_clock_out))
    else $error("clock pin does not follow enable");
  a_pin_off_disabled: assert property (!o_clock_pin_oe |-> !o_clock_pin)
    else $error("clock pin driven while disabled");
  a_por_clears_oe: assert property (disable iff (1'b0) !i_por_nrst |=> !o_clock_pin_oe)
    else $error("enable not cleared by power-on reset");
  a_oe_kept: assert property (disable iff (!i_por_nrst) i_por_nrst && !i_wr |=> $stable(o_clock_pin_oe))
    else $error("enable changed without a write");
  a_oe_write: assert property (disable iff (!i_por_nrst) i_wr && i_addr == CVW_ADDR_CONFIG
    |=> o_clock_pin_oe == $past(i_wdata[CVW_BIT_OUTPUT_ENABLE]))
    else $error("enable bit not written");
  a_low_keeps_ptr: assert property (s_low_twice |=> o_rdata == $past(o_rdata, 2))
    else $error("low window read moved the pointer");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero when idle");
endmodule
bind cvw_value_window cvw_value_window_monitor #(.HALF_CYCLES(HALF_CYCLES)) i_mon (.i_ref_clk(i_ref_clk),
  .i_nrst(i_nrst), .i_por_nrst(i_por_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_clock_out(i_clock_out), .o_rdata(o_rdata), .o_clock_pin(o_clock_pin), .o_clock_pin_oe(o_clock_pin_oe),
  .o_second_tick(o_second_tick));
